// *** sfms_top.sv ***
// Operation
// R1: serial port runs only while port_on is set; clearing it clears sticky flags.
// R2: host_select 1 makes us clock master; 0 makes us a slave.
// R3: generated serial clock idles at idle_clock_level.
// R4: master shifts on rising edge when shift_phase differs from idle level, else falling.
// R5: master samples on rising edge if host_sample_edge is 1, else falling.
// R6: slave samples rising, shifts falling when polarity equals phase; otherwise reversed.
// R7: interrupt reaches the processor only while irq_en_bit is set.
// R8: transfer interrupt after threshold code plus one bytes.
// R9: writing queue_flush empties both fifos.
// R10: master clock divider codes select divide by 6 up to 512.
// R11: bit_order 1 sends msb first, 0 lsb first.
// R12: transfer_done_flag sets on completion; cleared by writing 0 or disabling.
// R13: byte received while rx fifo full sets rx_overrun_flag.
// R14: data write while tx fifo full sets tx_overrun_flag.
// R15: transmission with tx fifo empty sets tx_underrun_flag.
// R16: rx_full and rx_empty are read-only fifo status.
// R17: tx_full and tx_empty are read-only fifo status.
// R18: data register reads pop rx fifo, writes push tx fifo.
// R19: four-byte transmit fifo and separate four-byte receive fifo.
// R20: external master selects us in slave mode with active-low slave enable.
// R21: enabled master clocks out bytes while tx fifo holds data.
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module sfms_top (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [11:0] awaddr,
    input  wire logic        wvalid,
    output logic             wready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    output logic             bvalid,
    input  wire logic        bready,
    output logic      [1:0]  bresp,
    input  wire logic        arvalid,
    output logic             arready,
    input  wire logic [11:0] araddr,
    output logic             rvalid,
    input  wire logic        rready,
    output logic      [31:0] rdata,
    output logic      [1:0]  rresp,
    input  wire logic        sclkIn,
    output logic             sclkOut,
    output logic             sclkOeN,
    input  wire logic        mosiIn,
    output logic             mosiOut,
    output logic             mosiOeN,
    input  wire logic        misoIn,
    output logic             misoOut,
    output logic             misoOeN,
    input  wire logic        slaveSelN,
    output logic             irq
);
    function automatic logic hit(input logic [11:0] a, input logic [11:0] t);
        hit = (a[11:2] == t[11:2]);
    endfunction
    function automatic logic [7:0] shf(input logic [7:0] v, input logic b, input logic msb);
        shf = msb ? {v[6:0], b} : {b, v[7:1]}; // [R11]
    endfunction
    function automatic logic [8:0] halfDiv(input logic [2:0] sel);
        halfDiv = sfms_pkg::HALF_TBL[sel];
    endfunction

    // pin synchroniser: {slaveSelN, misoIn, mosiIn, sclkIn}
    logic [3:0] s1_r;
    logic [3:0] s2_r;
    logic [3:0] s3_r;
    logic [3:0] pin_r;
    logic [3:0] pinPrev_r;
    logic [3:0] pin_nxt;
    always_comb begin
        pin_nxt = (s2_r & ~(s2_r ^ s3_r)) | (pin_r & (s2_r ^ s3_r));
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_r      <= sfms_pkg::PIN_RST;
            s2_r      <= sfms_pkg::PIN_RST;
            s3_r      <= sfms_pkg::PIN_RST;
            pin_r     <= sfms_pkg::PIN_RST;
            pinPrev_r <= sfms_pkg::PIN_RST;
        end else begin
            s1_r      <= {slaveSelN, misoIn, mosiIn, sclkIn};
            s2_r      <= s1_r;
            s3_r      <= s2_r;
            pin_r     <= pin_nxt;
            pinPrev_r <= pin_r;
        end
    end
    logic sRise;
    logic sFall;
    assign sRise = pin_r[0] && !pinPrev_r[0];
    assign sFall = !pin_r[0] && pinPrev_r[0];

    // registers
    logic [7:2] cfg_r;
    logic [7:2] cfg_nxt;
    logic [7:0] mode_r;
    logic [7:0] mode_nxt;
    logic [3:0] flags_r;
    logic [3:0] flags_nxt;
    logic [1:0] cnt_r;
    logic [1:0] cnt_nxt;
    logic       portOn;
    logic       hostSel;
    logic       idle_clock_level;
    logic       shift_phase;
    logic       msbFirst;
    assign portOn   = cfg_r[sfms_pkg::CFG_ON];
    assign hostSel  = cfg_r[sfms_pkg::CFG_HOST];
    assign idle_clock_level     = cfg_r[sfms_pkg::CFG_IDLE_CLOCK_LEVEL];
    assign shift_phase     = cfg_r[sfms_pkg::CFG_SHIFT_PHASE];
    assign msbFirst = mode_r[sfms_pkg::MODE_ORDER];

    // axi-lite slave state
    logic        awHeld_r, awHeld_nxt, wHeld_r, wHeld_nxt;
    logic [11:0] awAddr_r, awAddr_nxt;
    logic [7:0]  wData_r, wData_nxt;
    logic        wStrb_r, wStrb_nxt;
    logic        bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
    logic        awready_r, awready_nxt, wready_r, wready_nxt, arready_r, arready_nxt;
    logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [7:0]  rdata_r, rdata_nxt;
    logic        wrFire, arFire, wrCfg, wrMode, wrStat, wrData;
    assign wrFire = awHeld_r && wHeld_r && !bvalid_r;
    assign arFire = arvalid && arready_r;
    assign wrCfg  = wrFire && wStrb_r && hit(awAddr_r, sfms_pkg::CFG_ADDR);
    assign wrMode = wrFire && wStrb_r && hit(awAddr_r, sfms_pkg::MODE_ADDR);
    assign wrStat = wrFire && wStrb_r && hit(awAddr_r, sfms_pkg::STAT_ADDR);
    assign wrData = wrFire && wStrb_r && hit(awAddr_r, sfms_pkg::DATA_ADDR);

    // fifos
    logic       flush, txPush, txPopEng, txFull, txEmpty;
    logic       rxPush, rxPop, rxFull, rxEmpty;
    logic [7:0] txHead, rxHead;
    logic [7:0] rxSh_r, rxSh_nxt;
    assign flush  = wrMode && wData_r[sfms_pkg::MODE_FLUSH]; // [R9]
    assign txPush = wrData && !txFull; // [R18]
    assign rxPop  = arFire && hit(araddr, sfms_pkg::DATA_ADDR) && !rxEmpty; // [R18]

    sfms_fifo txFifo ( // [R19]
        .clk   (clk),
        .rst   (rst),
        .flush (flush),
        .push  (txPush),
        .din   (wData_r),
        .pop   (txPopEng),
        .dout  (txHead),
        .full  (txFull),
        .empty (txEmpty)
    );
    sfms_fifo rxFifo ( // [R19]
        .clk   (clk),
        .rst   (rst),
        .flush (flush),
        .push  (rxPush),
        .din   (rxSh_nxt),
        .pop   (rxPop),
        .dout  (rxHead),
        .full  (rxFull),
        .empty (rxEmpty)
    );

    // serial engine
    sfms_pkg::sfms_state_t st_r, st_nxt;
    logic [8:0] hc_r, hc_nxt;
    logic [3:0] ec_r, ec_nxt;
    logic [2:0] bc_r, bc_nxt;
    logic       ld_r, ld_nxt, sclk_r, sclk_nxt;
    logic [7:0] txSh_r, txSh_nxt;
    logic       byteDone, underrun, sampleEdge, shiftEdge;
    assign sampleEdge = (idle_clock_level == shift_phase) ? sRise : sFall; // [R6]
    assign shiftEdge  = (idle_clock_level == shift_phase) ? sFall : sRise; // [R6]
    assign rxPush     = byteDone && !rxFull;

    always_comb begin
        st_nxt   = st_r;
        hc_nxt   = hc_r;
        ec_nxt   = ec_r;
        bc_nxt   = bc_r;
        ld_nxt   = ld_r;
        sclk_nxt = sclk_r;
        txSh_nxt = txSh_r;
        rxSh_nxt = rxSh_r;
        txPopEng = 1'b0;
        byteDone = 1'b0;
        underrun = 1'b0;
        unique case (st_r)
            sfms_pkg::ST_IDLE: begin
                sclk_nxt = idle_clock_level; // [R3]
                hc_nxt   = 9'h000;
                ec_nxt   = 4'h0;
                bc_nxt   = 3'h0;
                ld_nxt   = 1'b0;
                if (portOn && hostSel && !txEmpty) begin // [R1] [R2] [R21]
                    st_nxt   = sfms_pkg::ST_HOST;
                    txPopEng = 1'b1;
                    txSh_nxt = txHead;
                end else if (portOn && !hostSel && !pin_r[3]) begin // [R20]
                    st_nxt = sfms_pkg::ST_DEV;
                end
            end
            sfms_pkg::ST_HOST: begin
                if (!portOn || !hostSel) begin
                    st_nxt   = sfms_pkg::ST_IDLE;
                    sclk_nxt = idle_clock_level; // [R3]
                end else if (hc_r == halfDiv(mode_r[3:1]) - 9'h001) begin // [R10]
                    hc_nxt   = 9'h000;
                    sclk_nxt = !sclk_r;
                    ec_nxt   = ec_r + 4'h1;
                    if ((!sclk_r == (idle_clock_level ^ shift_phase)) && ec_r != 4'h0) begin // [R4]
                        txSh_nxt = shf(txSh_r, 1'b0, msbFirst);
                    end
                    if (!sclk_r == cfg_r[sfms_pkg::CFG_HOST_SAMPLE_EDGE]) begin // [R5]
                        rxSh_nxt = shf(rxSh_r, pin_r[2], msbFirst);
                    end
                    if (ec_r == sfms_pkg::LAST_EDGE) begin
                        byteDone = 1'b1;
                        if (!txEmpty) begin // [R21]
                            txPopEng = 1'b1;
                            txSh_nxt = txHead;
                        end else begin
                            st_nxt = sfms_pkg::ST_IDLE;
                        end
                    end
                end else begin
                    hc_nxt = hc_r + 9'h001;
                end
            end
            sfms_pkg::ST_DEV: begin
                if (!portOn || hostSel || pin_r[3]) begin
                    st_nxt = sfms_pkg::ST_IDLE;
                end else begin
                    if (!ld_r) begin
                        ld_nxt = 1'b1;
                        if (!txEmpty) begin
                            txPopEng = 1'b1;
                            txSh_nxt = txHead;
                        end else begin
                            txSh_nxt = 8'h00;
                            underrun = 1'b1; // [R15]
                        end
                    end else if (shiftEdge && bc_r != 3'h0) begin
                        txSh_nxt = shf(txSh_r, 1'b0, msbFirst);
                    end
                    if (sampleEdge) begin
                        rxSh_nxt = shf(rxSh_r, pin_r[1], msbFirst);
                        bc_nxt   = bc_r + 3'h1;
                        if (bc_r == sfms_pkg::LAST_BIT) begin
                            byteDone = 1'b1;
                            ld_nxt   = 1'b0;
                        end
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_r   <= sfms_pkg::ST_IDLE;
            hc_r   <= 9'h000;
            ec_r   <= 4'h0;
            bc_r   <= 3'h0;
            ld_r   <= 1'b0;
            sclk_r <= 1'b0;
            txSh_r <= 8'h00;
            rxSh_r <= 8'h00;
        end else begin
            st_r   <= st_nxt;
            hc_r   <= hc_nxt;
            ec_r   <= ec_nxt;
            bc_r   <= bc_nxt;
            ld_r   <= ld_nxt;
            sclk_r <= sclk_nxt;
            txSh_r <= txSh_nxt;
            rxSh_r <= rxSh_nxt;
        end
    end

    // register file, bus answers and pin outputs
    logic dOut_r, dOut_nxt, sclkOeN_r, sclkOeN_nxt, misoOeN_r, misoOeN_nxt, irq_r, irq_nxt;
    always_comb begin
        cfg_nxt   = cfg_r;
        mode_nxt  = mode_r;
        flags_nxt = flags_r;
        cnt_nxt   = cnt_r;
        if (wrCfg) begin
            cfg_nxt = wData_r[7:2];
        end
        if (wrMode) begin
            mode_nxt = wData_r & sfms_pkg::MODE_MASK;
        end
        if (wrStat) begin
            flags_nxt = flags_r & wData_r[7:4]; // [R12]
        end
        if (byteDone) begin
            if (cnt_r == mode_r[7:6]) begin // [R8]
                cnt_nxt = 2'h0;
                flags_nxt[sfms_pkg::SB_DONE - 4] = 1'b1; // [R12]
            end else begin
                cnt_nxt = cnt_r + 2'h1;
            end
            if (rxFull) begin
                flags_nxt[sfms_pkg::SB_RX_OVERRUN_FLAG - 4] = 1'b1; // [R13]
            end
        end
        if (wrData && txFull) begin
            flags_nxt[sfms_pkg::SB_TX_OVERRUN_FLAG - 4] = 1'b1; // [R14]
        end
        if (underrun) begin
            flags_nxt[sfms_pkg::SB_TX_UNDERRUN_FLAG - 4] = 1'b1; // [R15]
        end
        if (!portOn) begin
            flags_nxt = sfms_pkg::FLAGS_RST; // [R1]
            cnt_nxt   = 2'h0;
        end
        irq_nxt     = cfg_r[sfms_pkg::CFG_IRQEN] && (flags_r != 4'h0); // [R7]
        dOut_nxt    = msbFirst ? txSh_nxt[7] : txSh_nxt[0]; // [R11]
        sclkOeN_nxt = !(portOn && hostSel); // [R2]
        misoOeN_nxt = (st_nxt != sfms_pkg::ST_DEV);
        // write channel
        awHeld_nxt = awHeld_r;
        wHeld_nxt  = wHeld_r;
        awAddr_nxt = awAddr_r;
        wData_nxt  = wData_r;
        wStrb_nxt  = wStrb_r;
        bvalid_nxt = bvalid_r && !bready;
        bresp_nxt  = bresp_r;
        if (awvalid && awready_r) begin
            awHeld_nxt = 1'b1;
            awAddr_nxt = awaddr;
        end
        if (wvalid && wready_r) begin
            wHeld_nxt = 1'b1;
            wData_nxt = wdata[7:0];
            wStrb_nxt = wstrb[0];
        end
        if (wrFire) begin
            awHeld_nxt = 1'b0;
            wHeld_nxt  = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt  = (hit(awAddr_r, sfms_pkg::CFG_ADDR) || hit(awAddr_r, sfms_pkg::MODE_ADDR) ||
                          hit(awAddr_r, sfms_pkg::STAT_ADDR) || hit(awAddr_r, sfms_pkg::DATA_ADDR))
                         ? sfms_pkg::RESP_OKAY : sfms_pkg::RESP_SLVERR;
        end
        awready_nxt = !awHeld_nxt && !bvalid_nxt;
        wready_nxt  = !wHeld_nxt && !bvalid_nxt;
        // read channel
        rvalid_nxt = rvalid_r && !rready;
        rdata_nxt  = rdata_r;
        rresp_nxt  = rresp_r;
        if (arFire) begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = sfms_pkg::RESP_OKAY;
            if (hit(araddr, sfms_pkg::CFG_ADDR)) begin
                rdata_nxt = {cfg_r, 2'b00};
            end else if (hit(araddr, sfms_pkg::MODE_ADDR)) begin
                rdata_nxt = mode_r;
            end else if (hit(araddr, sfms_pkg::STAT_ADDR)) begin
                rdata_nxt = {flags_r, rxFull, rxEmpty, txFull, txEmpty}; // [R16] [R17]
            end else if (hit(araddr, sfms_pkg::DATA_ADDR)) begin
                rdata_nxt = rxHead; // [R18]
            end else begin
                rdata_nxt = 8'h00;
                rresp_nxt = sfms_pkg::RESP_SLVERR;
            end
        end
        arready_nxt = !rvalid_nxt;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_r     <= sfms_pkg::CFG_RST;
            mode_r    <= sfms_pkg::MODE_RST;
            flags_r   <= sfms_pkg::FLAGS_RST;
            cnt_r     <= 2'h0;
            irq_r     <= 1'b0;
            dOut_r    <= 1'b0;
            sclkOeN_r <= 1'b1;
            misoOeN_r <= 1'b1;
            awHeld_r  <= 1'b0;
            wHeld_r   <= 1'b0;
            awAddr_r  <= 12'h000;
            wData_r   <= 8'h00;
            wStrb_r   <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= sfms_pkg::RESP_OKAY;
            awready_r <= 1'b0;
            wready_r  <= 1'b0;
            rvalid_r  <= 1'b0;
            rdata_r   <= 8'h00;
            rresp_r   <= sfms_pkg::RESP_OKAY;
            arready_r <= 1'b0;
        end else begin
            cfg_r     <= cfg_nxt;
            mode_r    <= mode_nxt;
            flags_r   <= flags_nxt;
            cnt_r     <= cnt_nxt;
            irq_r     <= irq_nxt;
            dOut_r    <= dOut_nxt;
            sclkOeN_r <= sclkOeN_nxt;
            misoOeN_r <= misoOeN_nxt;
            awHeld_r  <= awHeld_nxt;
            wHeld_r   <= wHeld_nxt;
            awAddr_r  <= awAddr_nxt;
            wData_r   <= wData_nxt;
            wStrb_r   <= wStrb_nxt;
            bvalid_r  <= bvalid_nxt;
            bresp_r   <= bresp_nxt;
            awready_r <= awready_nxt;
            wready_r  <= wready_nxt;
            rvalid_r  <= rvalid_nxt;
            rdata_r   <= rdata_nxt;
            rresp_r   <= rresp_nxt;
            arready_r <= arready_nxt;
        end
    end

    assign awready = awready_r;
    assign wready  = wready_r;
    assign bvalid  = bvalid_r;
    assign bresp   = bresp_r;
    assign arready = arready_r;
    assign rvalid  = rvalid_r;
    assign rdata   = {24'h0000_00, rdata_r};
    assign rresp   = rresp_r;
    assign sclkOut = sclk_r;
    assign sclkOeN = sclkOeN_r;
    assign mosiOut = dOut_r;
    assign mosiOeN = sclkOeN_r;
    assign misoOut = dOut_r;
    assign misoOeN = misoOeN_r;
    assign irq     = irq_r;

    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    AST_OFF_CLEARS: assert property (!portOn |=> flags_r == 4'h0) // [R1]
        else $error("flags not cleared while disabled");
    AST_SCLK_DRIVE: assert property (!sclkOeN |-> $past(portOn && hostSel)) // [R2]
        else $error("serial clock driven outside master mode");
    AST_IDLE_LEVEL: assert property (st_r == sfms_pkg::ST_IDLE && $stable(cfg_r) |-> sclkOut == idle_clock_level) // [R3]
        else $error("idle serial clock level wrong");
    AST_HALF_PERIOD: assert property (st_r == sfms_pkg::ST_HOST && $changed(sclk_r) && $past(st_r) == sfms_pkg::ST_HOST
        |-> $past(hc_r) == halfDiv(mode_r[3:1]) - 9'h001) // [R10]
        else $error("serial clock half period wrong");
    AST_IRQ_GATE: assert property (irq |-> $past(cfg_r[sfms_pkg::CFG_IRQEN]) && $past(flags_r) != 4'h0) // [R7]
        else $error("interrupt without enable or flag");
    AST_FLUSH: assert property (flush |=> txEmpty && rxEmpty) // [R9]
        else $error("flush left data in a fifo");
    AST_TX_OVR: assert property (wrData && txFull && portOn |=> flags_r[sfms_pkg::SB_TX_OVERRUN_FLAG - 4]) // [R14]
        else $error("tx overrun not flagged");
    AST_RX_OVR: assert property (byteDone && rxFull && portOn |=> flags_r[sfms_pkg::SB_RX_OVERRUN_FLAG - 4]) // [R13]
        else $error("rx overrun not flagged");
    AST_DONE_CNT: assert property (byteDone && portOn && cnt_r == mode_r[7:6] |=> flags_r[sfms_pkg::SB_DONE - 4]) // [R8]
        else $error("done flag not set at threshold");
    AST_AUTO_START: assert property (st_r == sfms_pkg::ST_IDLE && portOn && hostSel && !txEmpty
        |=> st_r == sfms_pkg::ST_HOST) // [R21]
        else $error("master did not start with data queued");
endmodule // sfms_top
`default_nettype wire

// *** sfms_pkg.sv ***
package sfms_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0]  CFG_IDX    = 8'ha1;
    localparam logic [7:0]  MODE_IDX   = 8'ha2;
    localparam logic [7:0]  STAT_IDX   = 8'ha3;
    localparam logic [7:0]  DATA_IDX   = 8'ha4;
    localparam logic [11:0] CFG_ADDR   = {2'b00, CFG_IDX, 2'b00};
    localparam logic [11:0] MODE_ADDR  = {2'b00, MODE_IDX, 2'b00};
    localparam logic [11:0] STAT_ADDR  = {2'b00, STAT_IDX, 2'b00};
    localparam logic [11:0] DATA_ADDR  = {2'b00, DATA_IDX, 2'b00};
    // config fields (cfg register holds bits 7..2)
    localparam int CFG_IRQEN = 7;
    localparam int CFG_ON    = 6;
    localparam int CFG_HOST  = 5;
    localparam int CFG_IDLE_CLOCK_LEVEL  = 4;
    localparam int CFG_SHIFT_PHASE  = 3;
    localparam int CFG_HOST_SAMPLE_EDGE  = 2;
    // mode fields
    localparam int MODE_THR   = 6;
    localparam int MODE_FLUSH = 5;
    localparam int MODE_DIV   = 1;
    localparam int MODE_ORDER = 0;
    localparam logic [7:0] MODE_MASK = 8'hcf;
    // status flag positions within the status register
    localparam int SB_DONE = 7;
    localparam int SB_RX_OVERRUN_FLAG = 6;
    localparam int SB_TX_OVERRUN_FLAG = 5;
    localparam int SB_TX_UNDERRUN_FLAG = 4;
    // reset values
    localparam logic [7:2] CFG_RST   = 6'h08;
    localparam logic [7:0] MODE_RST  = 8'h00;
    localparam logic [3:0] FLAGS_RST = 4'h0;
    localparam logic [3:0] PIN_RST   = 4'h8;
    // fifo and frame counts
    localparam int         FIFO_DEPTH = 4;
    localparam logic [3:0] LAST_EDGE  = 4'hf;
    localparam logic [2:0] LAST_BIT   = 3'h7;
    // half period of the serial clock in system clocks, per divider code
    localparam logic [8:0] HALF_TBL [8] = '{9'h003, 9'h004, 9'h008, 9'h010,
                                           9'h020, 9'h040, 9'h080, 9'h100};
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_HOST = 3'b010,
        ST_DEV  = 3'b100
    } sfms_state_t;
endpackage

// *** sfms_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none
module sfms_fifo (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       flush,
    input  wire logic       push,
    input  wire logic [7:0] din,
    input  wire logic       pop,
    output logic      [7:0] dout,
    output logic            full,
    output logic            empty
);
    logic [7:0] mem [sfms_pkg::FIFO_DEPTH];
    logic [1:0] wp_r;
    logic [1:0] wp_nxt;
    logic [1:0] rp_r;
    logic [1:0] rp_nxt;
    logic [2:0] cnt_r;
    logic [2:0] cnt_nxt;
    logic       doPush;
    logic       doPop;

    assign full   = (cnt_r == 3'(sfms_pkg::FIFO_DEPTH));
    assign empty  = (cnt_r == 3'h0);
    assign dout   = mem[rp_r];
    assign doPush = push && !full;
    assign doPop  = pop && !empty;

    always_comb begin
        wp_nxt  = wp_r + 2'(doPush);
        rp_nxt  = rp_r + 2'(doPop);
        cnt_nxt = cnt_r + 3'(doPush) - 3'(doPop);
        if (flush) begin
            wp_nxt  = 2'h0;
            rp_nxt  = 2'h0;
            cnt_nxt = 3'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wp_r  <= 2'h0;
            rp_r  <= 2'h0;
            cnt_r <= 3'h0;
        end else begin
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
        if (doPush && !flush) begin
            mem[wp_r] <= din;
        end
    end
endmodule // sfms_fifo
`default_nettype wire

// *** sfms_peer_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module sfms_peer_model (
    input  wire logic       sclk,
    input  wire logic       mosi,
    output logic            miso,
    output logic      [7:0] got
);
    logic [7:0] rx   = 8'h00;
    logic [7:0] tx   = 8'h3c;
    logic [2:0] n    = 3'h0;
    initial miso = tx[7];
    initial got  = 8'h00;
    // sample on rising edge, msb first
    always @(posedge sclk) begin
        rx = {rx[6:0], mosi};
        n = n + 3'h1;
        if (n == 3'h0) got = rx;
    end
    // shift on falling edge; a spent byte restarts at its msb
    always @(negedge sclk) begin
        miso = tx[3'h7 - n];
    end
endmodule // sfms_peer_model
`default_nettype wire

// *** tb_spi_fifo_master_slave.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_errors++; $display("unexpected %0t %h %h", $time, a, e); end end
module tb_spi_fifo_master_slave;
    logic        clk = 1'b0, rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0;
    logic        bready = 1'b0, arvalid = 1'b0, rready = 1'b0, sPrev = 1'b0;
    logic [11:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0;
    logic [3:0]  wstrb = 4'h1;
    logic        awready, wready, bvalid, arready, rvalid, sclkOut, mosiOut, misoIn, irq;
    logic        misoOut, sclkOeN, mosiOeN, misoOeN;
    logic        sclkIn = 1'b0, mosiIn = 1'b0, slaveSelN = 1'b1;
    logic [1:0]  bresp, rresp, r;
    logic [31:0] rdata;
    logic [7:0]  got, d, s;
    int          n_errors = 0, tests_run = 0, cnt = 0, per = 0;
    sfms_top u_dut (.clk, .rst, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid,
        .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .sclkIn,
        .sclkOut, .sclkOeN, .mosiIn, .mosiOut, .mosiOeN, .misoIn, .misoOut, .misoOeN,
        .slaveSelN, .irq);
    sfms_peer_model u_peer (.sclk(sclkOut), .mosi(mosiOut), .miso(misoIn), .got);
    always #50 clk = ~clk;
    // serial clock period in system clocks, rise to rise
    always @(posedge clk) begin
        sPrev <= sclkOut;
        cnt <= (sclkOut && !sPrev) ? 1 : cnt + 1;
        if (sclkOut && !sPrev) per <= cnt;
    end
    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        logic ad, wd;
        ad = 1'b0;
        wd = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h00_0000, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            ad = ad | awready;
            wd = wd | wready;
            if (ad) awvalid <= 1'b0;
            if (wd) wvalid <= 1'b0;
        end while (!(ad && wd));
        do @(posedge clk); while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clk); while (!rvalid);
        d = rdata[7:0];
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic rc(input logic [11:0] a, input logic [7:0] e);
        rd(a);
        `CHK(d, e)
    endtask
    // external master, mode 0, lsb first, 800 ns serial clock
    task automatic xfer(input logic [7:0] m);
        slaveSelN <= 1'b0;
        repeat (4) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            mosiIn <= m[i];
            repeat (4) @(posedge clk);
            sclkIn <= 1'b1;
            repeat (4) @(posedge clk);
            s[i] = misoOut;
            sclkIn <= 1'b0;
        end
        `CHK({sclkOeN, misoOeN}, 2'b10)
        repeat (8) @(posedge clk);
        slaveSelN <= 1'b1;
    endtask
    task close_out;
        if (n_errors == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #5_000_000;
        n_errors++;
        close_out;
    end
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rc(sfms_pkg::CFG_ADDR, 8'h20);
        rc(sfms_pkg::MODE_ADDR, 8'h00);
        rc(sfms_pkg::STAT_ADDR, 8'h05);
        rd(12'h000);
        `CHK(r, sfms_pkg::RESP_SLVERR)
        // idle slave: fill tx until it refuses
        wr(sfms_pkg::CFG_ADDR, 8'hc0);
        repeat (5) wr(sfms_pkg::DATA_ADDR, 8'h11);
        rc(sfms_pkg::STAT_ADDR, 8'h26);
        `CHK(irq, 1'b1)
        wr(sfms_pkg::STAT_ADDR, 8'hff);
        rc(sfms_pkg::STAT_ADDR, 8'h26);
        wr(sfms_pkg::MODE_ADDR, 8'h20);
        rc(sfms_pkg::STAT_ADDR, 8'h25);
        wr(sfms_pkg::CFG_ADDR, 8'h40);
        @(posedge clk);
        `CHK(irq, 1'b0)
        wr(sfms_pkg::CFG_ADDR, 8'h00);
        rc(sfms_pkg::STAT_ADDR, 8'h05);
        // master byte, divider code 2, msb first, mode 0 with rising sample
        wr(sfms_pkg::MODE_ADDR, 8'h05);
        wr(sfms_pkg::CFG_ADDR, 8'he4);
        wr(sfms_pkg::DATA_ADDR, 8'ha5);
        d = 8'h00;
        for (int i = 0; i < 80 && !d[7]; i++) rd(sfms_pkg::STAT_ADDR);
        `CHK(d, 8'h81)
        `CHK(irq, 1'b1)
        `CHK(got, 8'ha5)
        `CHK(per, 16)
        `CHK(sclkOut, 1'b0)
        `CHK({sclkOeN, mosiOeN}, 2'b00)
        rc(sfms_pkg::DATA_ADDR, 8'h3c);
        wr(sfms_pkg::STAT_ADDR, 8'h00);
        rc(sfms_pkg::STAT_ADDR, 8'h05);
        // slave byte; the reload after it finds tx empty
        wr(sfms_pkg::CFG_ADDR, 8'h40);
        wr(sfms_pkg::MODE_ADDR, 8'h04);
        wr(sfms_pkg::DATA_ADDR, 8'h96);
        `CHK(r, sfms_pkg::RESP_OKAY)
        xfer(8'h5a);
        `CHK(s, 8'h96)
        rc(sfms_pkg::STAT_ADDR, 8'h91);
        rc(sfms_pkg::DATA_ADDR, 8'h5a);
        close_out;
    end
endmodule // tb_spi_fifo_master_slave
`default_nettype wire
